/* verilog/mscr_top.sv */
// serial command decoder, status register and normal register bank
// Operation
// - codes 0x49 and 0x4a read or write the 8-bit status, always accepted.
// - with unlock clear, every other command is ignored; set accepts all.
// - code 0x51 takes an address, then returns that 16-bit register.
// - code 0x52 takes an address and 16 bits, stored into that register.
// - code 0x59 copies non-volatile storage into the normal registers.
// - code 0x5a starts writing normal registers into non-volatile storage.
// - code 0x5c forcibly ends a storage write in progress.
// - status bit 0 is one while a storage operation runs.
// - link mode 0: clock on speed pin, data in tach, data out alert.
// - link mode 1: clock on speed pin, both directions share tach pin.
// - status bit 3 zero allows storage reads, one allows storage writes.
// - status bit 4 reports hall detection failure.
// - register 1 holds nonstop enable, stop and startup thresholds.
// - register 2 holds change point and clamp thresholds.
// - register 3 holds startup speed and open loop return hysteresis.
// - register 4 holds primary slope and two speed enables.
// - register 5 holds secondary slope, reverse alarm and loop select.
// - register 6 holds integral and proportional gains with x8 flags.
// - register 7 holds standby, direction, poles, speed range and hall setup.
// - register 8 high bits: tach source, tach type, speed input type.
// - register 8 middle bits: speed polarity, reverse start, commutation, latch.
// - register 8 low bits: mask period, limit disable, threshold, pwm frequency.
// - commands are taken only while the tach pin is not driven.
// - only registers 0 to 8 travel to and from storage.
`timescale 1ns/1ps

module mscr_top #(
	parameter int NONVOL_COMMIT_CMD_CYCLES = mscr_pkg::NONVOL_COMMIT_CMD_CYCLES
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	// serial link pins
	input  wire logic        speed_input_pin,
	input  wire logic        host_to_dev_line,
	output logic             tach_output_pin,
	output logic             tach_output_oe,
	output logic             dev_to_host_line,
	output logic             dev_to_host_oe,
	// motor core side
	input  wire logic        tach_drive_req,
	input  wire logic        tach_signal,
	input  wire logic        hall_cal_fail,
	// status and configuration
	output logic [7:0]       link_status_ctrl,
	output logic [15:0]      user_identifier,
	output logic [15:0]      start_stop_thresholds,
	output logic [15:0]      clamp_change_points,
	output logic [15:0]      startup_speed_hys,
	output logic [15:0]      slope_primary_ctrl,
	output logic [15:0]      slope_secondary_ctrl,
	output logic [15:0]      loop_gains,
	output logic [15:0]      motor_hall_config,
	output logic [15:0]      drive_protect_config
);

	////////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic                                            sck_s1;
		logic                                            sck_s2;
		logic                                            sck_d;
		logic                                            din_s1;
		logic                                            din_s2;
		mscr_pkg::mscr_phase_t                           phase;
		logic [4:0]                                      cnt;
		logic [15:0]                                     shin;
		logic [7:0]                                      cmd;
		logic [7:0]                                      addr;
		logic [15:0]                                     tx;
		logic                                            out_bit;
		logic                                            out_en;
		logic [mscr_pkg::GAP_CNT_W-1:0]                  gap;
		logic                                            unlock;
		logic                                            wire_mode;
		logic                                            storage_write_mode;
		logic                                            cal_err;
		logic                                            busy;
		logic                                            load_op;
		logic [mscr_pkg::BUSY_CNT_W-1:0]                 busy_cnt;
		logic                                            fg_out;
		logic                                            fg_oe;
		logic                                            al_out;
		logic                                            al_oe;
		logic [mscr_pkg::NUM_REGS-1:0][15:0]             regs;
		logic [mscr_pkg::NUM_REGS-1:0][15:0]             nvm;
	} mscr_state_t;

	mscr_state_t st_reg;
	mscr_state_t st_next;

	logic        sck_rise;
	logic        sck_fall;
	logic        cmd_take;
	logic [7:0]  cmd_word;
	logic [7:0]  status_now;
	logic [4:0]  din_len;
	logic        frame_reset;

	localparam logic [mscr_pkg::BUSY_CNT_W-1:0] SAVE_CNT =
		mscr_pkg::BUSY_CNT_W'(NONVOL_COMMIT_CMD_CYCLES - 1);
	localparam logic [mscr_pkg::BUSY_CNT_W-1:0] LOAD_CNT =
		mscr_pkg::BUSY_CNT_W'(mscr_pkg::NONVOL_RESTORE_CMD_CYCLES - 1);
	localparam logic [mscr_pkg::GAP_CNT_W-1:0]  GAP_END  =
		mscr_pkg::GAP_CNT_W'(mscr_pkg::FRAME_GAP_CYCLES);

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		st_next = st_reg;
		st_next.sck_s1 = speed_input_pin;
		st_next.sck_s2 = st_reg.sck_s1;
		st_next.sck_d  = st_reg.sck_s2;
		st_next.din_s1 = host_to_dev_line;
		st_next.din_s2 = st_reg.din_s1;
		st_next.cal_err = hall_cal_fail;
		sck_rise = st_reg.sck_s2 & ~st_reg.sck_d;
		sck_fall = ~st_reg.sck_s2 & st_reg.sck_d;
		status_now = {3'h0, st_reg.cal_err, st_reg.storage_write_mode, st_reg.wire_mode, st_reg.unlock, st_reg.busy};
		cmd_word = {st_reg.shin[6:0], st_reg.din_s2};
		cmd_take = 1'b0;
		din_len = (st_reg.cmd == mscr_pkg::STATUS_STORE_CMD) ? mscr_pkg::STATUS_BITS : mscr_pkg::WORD_BITS;
		frame_reset = tach_drive_req || (st_reg.gap == GAP_END && !(sck_rise || sck_fall));

		// idle gap on the serial clock closes a frame
		if (sck_rise || sck_fall) begin
			st_next.gap = '0;
		end else if (st_reg.gap != GAP_END) begin
			st_next.gap = st_reg.gap + 1'b1;
		end

		// storage operation timer
		if (st_reg.busy) begin
			if (st_reg.busy_cnt == '0) begin
				st_next.busy = 1'b0;
				if (!st_reg.load_op) begin
					st_next.nvm = st_reg.regs;
				end
			end else begin
				st_next.busy_cnt = st_reg.busy_cnt - 1'b1;
			end
		end

		if (frame_reset) begin
			st_next.phase  = mscr_pkg::PH_CMD;
			st_next.cnt    = '0;
			st_next.out_en = 1'b0;
		end else if (sck_rise) begin
			st_next.shin = {st_reg.shin[14:0], st_reg.din_s2};
			st_next.cnt  = st_reg.cnt + 1'b1;
			case (st_reg.phase)
				mscr_pkg::PH_CMD: begin
					if (st_reg.cnt == mscr_pkg::CMD_BITS - 1'b1) begin
						cmd_take = 1'b1;
						st_next.cmd = cmd_word;
						st_next.cnt = '0;
						st_next.phase = mscr_pkg::PH_SKIP;
						if (cmd_word == mscr_pkg::STATUS_FETCH_CMD) begin
							st_next.tx = {status_now, 8'h00};
							st_next.phase = mscr_pkg::PH_DOUT;
						end else if (cmd_word == mscr_pkg::STATUS_STORE_CMD) begin
							st_next.phase = mscr_pkg::PH_DIN;
						end else if (!st_reg.unlock) begin
							st_next.phase = mscr_pkg::PH_SKIP;
						end else if (cmd_word == mscr_pkg::REG_FETCH_CMD || cmd_word == mscr_pkg::REG_STORE_CMD) begin
							st_next.phase = mscr_pkg::PH_ADDR;
						end else if (cmd_word == mscr_pkg::NONVOL_RESTORE_CMD) begin
							st_next.phase = mscr_pkg::PH_CMD;
							if (!st_reg.storage_write_mode && !st_reg.busy) begin
								st_next.regs     = st_reg.nvm;
								st_next.busy     = 1'b1;
								st_next.load_op  = 1'b1;
								st_next.busy_cnt = LOAD_CNT;
							end
						end else if (cmd_word == mscr_pkg::NONVOL_COMMIT_CMD) begin
							st_next.phase = mscr_pkg::PH_CMD;
							if (st_reg.storage_write_mode && !st_reg.busy) begin
								st_next.busy     = 1'b1;
								st_next.load_op  = 1'b0;
								st_next.busy_cnt = SAVE_CNT;
							end
						end else if (cmd_word == mscr_pkg::NONVOL_CANCEL_CMD) begin
							st_next.phase = mscr_pkg::PH_CMD;
							if (st_reg.busy && !st_reg.load_op) begin
								st_next.busy = 1'b0;
							end
						end
					end
				end
				mscr_pkg::PH_ADDR: begin
					if (st_reg.cnt == mscr_pkg::ADDR_BITS - 1'b1) begin
						st_next.addr = cmd_word;
						st_next.cnt  = '0;
						if (st_reg.cmd == mscr_pkg::REG_FETCH_CMD) begin
							st_next.phase = mscr_pkg::PH_DOUT;
							if (cmd_word < mscr_pkg::NUM_REGS_B) begin
								st_next.tx = st_reg.regs[cmd_word[3:0]];
							end else begin
								st_next.tx = 16'h0000;
							end
						end else begin
							st_next.phase = mscr_pkg::PH_DIN;
						end
					end
				end
				mscr_pkg::PH_DIN: begin
					if (st_reg.cnt == din_len - 1'b1) begin
						st_next.cnt   = '0;
						st_next.phase = mscr_pkg::PH_CMD;
						if (st_reg.cmd == mscr_pkg::STATUS_STORE_CMD) begin
							st_next.unlock    = st_reg.shin[mscr_pkg::ST_UNLOCK-1];
							st_next.wire_mode = st_reg.shin[mscr_pkg::ST_WIRE-1];
							st_next.storage_write_mode    = st_reg.shin[mscr_pkg::ST_STORAGE_WRITE_MODE-1];
						end else if (st_reg.addr < mscr_pkg::NUM_REGS_B) begin
							st_next.regs[st_reg.addr[3:0]] = {st_reg.shin[14:0], st_reg.din_s2};
						end
					end
				end
				mscr_pkg::PH_DOUT: begin
					if (st_reg.cnt == din_len - 1'b1 || (st_reg.cmd == mscr_pkg::STATUS_FETCH_CMD &&
						st_reg.cnt == mscr_pkg::STATUS_BITS - 1'b1)) begin
						st_next.cnt   = '0;
						st_next.phase = mscr_pkg::PH_CMD;
					end
				end
				default: begin
					st_next.cnt = st_reg.cnt;
				end
			endcase
		end else if (sck_fall) begin
			if (st_reg.phase == mscr_pkg::PH_DOUT) begin
				st_next.out_bit = st_reg.tx[15];
				st_next.tx      = {st_reg.tx[14:0], 1'b0};
				st_next.out_en  = 1'b1;
			end else begin
				st_next.out_en  = 1'b0;
			end
		end

		// pin steering by link mode; the motor core owns the tach pin when it drives
		if (tach_drive_req) begin
			st_next.fg_out = tach_signal;
			st_next.fg_oe  = 1'b1;
			st_next.al_out = 1'b0;
			st_next.al_oe  = 1'b0;
		end else if (st_reg.wire_mode) begin
			st_next.fg_out = st_next.out_bit;
			st_next.fg_oe  = st_next.out_en;
			st_next.al_out = 1'b0;
			st_next.al_oe  = 1'b0;
		end else begin
			st_next.fg_out = 1'b0;
			st_next.fg_oe  = 1'b0;
			st_next.al_out = st_next.out_bit;
			st_next.al_oe  = st_next.out_en;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '0;
			st_reg.phase <= mscr_pkg::PH_CMD;
			st_reg.regs <= {mscr_pkg::NUM_REGS{mscr_pkg::REG_RESET}};
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign tach_output_pin       = st_reg.fg_out;
	assign tach_output_oe        = st_reg.fg_oe;
	assign dev_to_host_line      = st_reg.al_out;
	assign dev_to_host_oe        = st_reg.al_oe;
	assign link_status_ctrl      = {3'h0, st_reg.cal_err, st_reg.storage_write_mode, st_reg.wire_mode, st_reg.unlock, st_reg.busy};
	assign user_identifier       = st_reg.regs[mscr_pkg::ADDR_USER_ID];
	assign start_stop_thresholds = st_reg.regs[mscr_pkg::ADDR_START_STOP];
	assign clamp_change_points   = st_reg.regs[mscr_pkg::ADDR_CLAMP_CHG];
	assign startup_speed_hys     = st_reg.regs[mscr_pkg::ADDR_STARTUP_HYS];
	assign slope_primary_ctrl    = st_reg.regs[mscr_pkg::ADDR_SLOPE_PRI];
	assign slope_secondary_ctrl  = st_reg.regs[mscr_pkg::ADDR_SLOPE_SEC];
	assign loop_gains            = st_reg.regs[mscr_pkg::ADDR_LOOP_GAINS];
	assign motor_hall_config     = st_reg.regs[mscr_pkg::ADDR_MOTOR_HALL];
	assign drive_protect_config  = st_reg.regs[mscr_pkg::ADDR_DRIVE_PROT];

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	sequence s_commit_taken;
		cmd_take && !frame_reset && cmd_word == mscr_pkg::NONVOL_COMMIT_CMD && st_reg.unlock && st_reg.storage_write_mode && !st_reg.busy;
	endsequence

	sequence s_restore_taken;
		cmd_take && !frame_reset && cmd_word == mscr_pkg::NONVOL_RESTORE_CMD && st_reg.unlock && !st_reg.storage_write_mode && !st_reg.busy;
	endsequence

	sequence s_cancel_taken;
		cmd_take && !frame_reset && cmd_word == mscr_pkg::NONVOL_CANCEL_CMD && st_reg.unlock && st_reg.busy && !st_reg.load_op;
	endsequence

	a_commit_busy: assert property (s_commit_taken |=> st_reg.busy && !st_reg.load_op)
		else $error("commit did not raise busy");
	a_cancel_ends: assert property (s_cancel_taken |=> !st_reg.busy)
		else $error("cancel left busy set");
	a_lock_ignore: assert property (cmd_take && !frame_reset && !st_reg.unlock &&
		cmd_word != mscr_pkg::STATUS_FETCH_CMD && cmd_word != mscr_pkg::STATUS_STORE_CMD
		|=> st_reg.phase == mscr_pkg::PH_SKIP && $stable(st_reg.busy))
		else $error("locked command was not ignored");
	a_restore_block: assert property (cmd_take && !frame_reset && cmd_word == mscr_pkg::NONVOL_RESTORE_CMD &&
		st_reg.storage_write_mode && !st_reg.busy |=> !st_reg.busy && $stable(st_reg.regs))
		else $error("restore ran in write mode");
	a_status_fetch: assert property (cmd_take && !frame_reset && cmd_word == mscr_pkg::STATUS_FETCH_CMD
		|=> st_reg.phase == mscr_pkg::PH_DOUT && st_reg.tx[15:8] == $past(status_now))
		else $error("status fetch loaded wrong data");
	a_reg_store: assert property (sck_rise && !frame_reset && st_reg.phase == mscr_pkg::PH_DIN &&
		st_reg.cmd == mscr_pkg::REG_STORE_CMD && st_reg.cnt == 5'h0f && st_reg.addr < mscr_pkg::NUM_REGS_B
		|=> st_reg.regs[$past(st_reg.addr[3:0])] == $past({st_reg.shin[14:0], st_reg.din_s2}))
		else $error("register store lost data");
	a_cal_mirror: assert property (##1 st_reg.cal_err == $past(hall_cal_fail))
		else $error("hall result not reported");
	a_wire_pins: assert property (st_reg.wire_mode && !tach_drive_req |=> !dev_to_host_oe)
		else $error("alert driven in two-wire mode");
	a_three_wire: assert property (!st_reg.wire_mode && !tach_drive_req |=> tach_output_oe == 1'b0)
		else $error("tach driven in three-wire mode");
	a_tach_owns: assert property (tach_drive_req |=> st_reg.phase == mscr_pkg::PH_CMD && st_reg.cnt == 5'h00)
		else $error("frame not held while tach driven");
	a_restore_busy: assert property (s_restore_taken |=> link_status_ctrl[mscr_pkg::ST_BUSY] ##19
		link_status_ctrl[mscr_pkg::ST_BUSY] ##1 !link_status_ctrl[mscr_pkg::ST_BUSY])
		else $error("restore busy window wrong");
	a_restore_load: assert property (s_restore_taken |=> st_reg.regs == $past(st_reg.nvm))
		else $error("restore did not load registers");
	a_status_store: assert property (sck_rise && !frame_reset && st_reg.phase == mscr_pkg::PH_DIN &&
		st_reg.cmd == mscr_pkg::STATUS_STORE_CMD && st_reg.cnt == 5'h07
		|=> link_status_ctrl[3:1] == $past(st_reg.shin[2:0]))
		else $error("status store lost bits");
	a_reg_fetch: assert property (sck_rise && !frame_reset && st_reg.phase == mscr_pkg::PH_ADDR &&
		st_reg.cmd == mscr_pkg::REG_FETCH_CMD && st_reg.cnt == 5'h07 && cmd_word < mscr_pkg::NUM_REGS_B
		|=> st_reg.phase == mscr_pkg::PH_DOUT && st_reg.tx == $past(st_reg.regs[cmd_word[3:0]]))
		else $error("register fetch loaded wrong data");
	a_unmapped_drop: assert property (sck_rise && !frame_reset && st_reg.phase == mscr_pkg::PH_DIN &&
		st_reg.cmd == mscr_pkg::REG_STORE_CMD && st_reg.cnt == 5'h0f && st_reg.addr >= mscr_pkg::NUM_REGS_B
		|=> $stable(st_reg.regs))
		else $error("unmapped store changed a register");
	a_shift_msb: assert property (sck_fall && !frame_reset && st_reg.phase == mscr_pkg::PH_DOUT
		|=> st_reg.out_bit == $past(st_reg.tx[15]) && st_reg.out_en)
		else $error("data out bit not msb first");
	a_gap_realign: assert property (st_reg.gap == GAP_END && !sck_rise && !sck_fall && !tach_drive_req
		|=> st_reg.phase == mscr_pkg::PH_CMD && st_reg.cnt == 5'h00 && !st_reg.out_en)
		else $error("idle gap did not realign frame");
	a_skip_hold: assert property (st_reg.phase == mscr_pkg::PH_SKIP && !frame_reset
		|=> st_reg.phase == mscr_pkg::PH_SKIP)
		else $error("ignored frame left skip phase");

endmodule

/* verilog/mscr_pkg.sv */
// constants shared by the serial command decoder and register bank
package mscr_pkg;

	// command codes, eight bits, sent first in every transaction
	localparam logic [7:0] STATUS_FETCH_CMD   = 8'h49;
	localparam logic [7:0] STATUS_STORE_CMD   = 8'h4a;
	localparam logic [7:0] REG_FETCH_CMD      = 8'h51;
	localparam logic [7:0] REG_STORE_CMD      = 8'h52;
	localparam logic [7:0] NONVOL_RESTORE_CMD = 8'h59;
	localparam logic [7:0] NONVOL_COMMIT_CMD  = 8'h5a;
	localparam logic [7:0] NONVOL_CANCEL_CMD  = 8'h5c;

	// status register bit positions
	localparam int ST_BUSY     = 0;
	localparam int ST_UNLOCK   = 1;
	localparam int ST_WIRE     = 2;
	localparam int ST_STORAGE_WRITE_MODE   = 3;
	localparam int ST_CAL_ERR  = 4;

	// normal register addresses
	localparam logic [3:0] ADDR_USER_ID     = 4'h0;
	localparam logic [3:0] ADDR_START_STOP  = 4'h1;
	localparam logic [3:0] ADDR_CLAMP_CHG   = 4'h2;
	localparam logic [3:0] ADDR_STARTUP_HYS = 4'h3;
	localparam logic [3:0] ADDR_SLOPE_PRI   = 4'h4;
	localparam logic [3:0] ADDR_SLOPE_SEC   = 4'h5;
	localparam logic [3:0] ADDR_LOOP_GAINS  = 4'h6;
	localparam logic [3:0] ADDR_MOTOR_HALL  = 4'h7;
	localparam logic [3:0] ADDR_DRIVE_PROT  = 4'h8;
	localparam int         NUM_REGS         = 9;
	localparam logic [7:0] NUM_REGS_B       = 8'h09;
	localparam logic [15:0] REG_RESET       = 16'h0000;
	localparam logic [7:0] STATUS_RESET     = 8'h00;

	// field widths of each transaction phase
	localparam logic [4:0] CMD_BITS    = 5'h08;
	localparam logic [4:0] ADDR_BITS   = 5'h08;
	localparam logic [4:0] STATUS_BITS = 5'h08;
	localparam logic [4:0] WORD_BITS   = 5'h10;

	// timing
	localparam int SYS_CLK_MHZ      = 200;
	localparam int FRAME_GAP_NS     = 1000;
	localparam int FRAME_GAP_CYCLES = (FRAME_GAP_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int NONVOL_RESTORE_CMD_NS      = 100;
	localparam int NONVOL_RESTORE_CMD_CYCLES  = (NONVOL_RESTORE_CMD_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int NONVOL_COMMIT_CMD_US      = 2000;
	localparam int NONVOL_COMMIT_CMD_CYCLES  = NONVOL_COMMIT_CMD_US * SYS_CLK_MHZ;
	localparam int BUSY_CNT_W       = 20;
	localparam int GAP_CNT_W        = 9;

	// transaction phases, gray coded along cmd, addr, data in/out
	typedef enum logic [2:0] {
		PH_CMD  = 3'h0,
		PH_ADDR = 3'h1,
		PH_DIN  = 3'h3,
		PH_DOUT = 3'h2,
		PH_SKIP = 3'h6
	} mscr_phase_t;

endpackage

/* dv/mscr_host_model.sv */
// host model that shifts command frames over the speed and tach pins
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module mscr_host_model (
	// serial clock and host data on the tach pin
	output logic      sck,
	output logic      host_oe,
	output logic      host_dat,
	// resolved pin levels
	input  wire logic tach_level,
	input  wire logic alert_level
);
	logic two_wire;
	initial begin
		sck      = 1'b0;
		host_oe  = 1'b0;
		host_dat = 1'b0;
		two_wire = 1'b0;
	end
	// one bit: data set after the fall, sampled at the rise, 125 ns period
	task automatic bitx(input logic drv, input logic bo, output logic bi);
		host_oe  = drv;
		host_dat = bo;
		#62.5 sck = 1'b1;
		bi = two_wire ? tach_level : alert_level;
		#62.5 sck = 1'b0;
	endtask
	task automatic tx8(input logic [7:0] v);
		logic d;
		for (int i = 7; i >= 0; i--) bitx(1'b1, v[i], d);
	endtask
	task automatic tx16(input logic [15:0] v);
		logic d;
		for (int i = 15; i >= 0; i--) bitx(1'b1, v[i], d);
	endtask
	task automatic rx8(output logic [7:0] v);
		for (int i = 7; i >= 0; i--) bitx(1'b0, 1'b0, v[i]);
	endtask
	task automatic rx16(output logic [15:0] v);
		for (int i = 15; i >= 0; i--) bitx(1'b0, 1'b0, v[i]);
	endtask
	// release the tach pin and let the frame gap run out
	task automatic gap();
		host_oe = 1'b0;
		#1200;
	endtask
	task automatic st_wr(input logic [7:0] v);
		tx8(mscr_pkg::STATUS_STORE_CMD);
		tx8(v);
		gap();
		two_wire = v[mscr_pkg::ST_WIRE];
	endtask
	task automatic st_rd(output logic [7:0] v);
		tx8(mscr_pkg::STATUS_FETCH_CMD);
		rx8(v);
		gap();
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [15:0] v);
		tx8(mscr_pkg::REG_STORE_CMD);
		tx8(a);
		tx16(v);
		gap();
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [15:0] v);
		tx8(mscr_pkg::REG_FETCH_CMD);
		tx8(a);
		rx16(v);
		gap();
	endtask
	task automatic cmd(input logic [7:0] c);
		tx8(c);
		gap();
	endtask
endmodule

/* dv/tb_top.sv */
// self-checking bench for the serial command decoder and register bank
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module tb_top;
	logic        sys_clk;
	logic        rstn;
	logic        sck;
	logic        host_oe;
	logic        host_dat;
	logic        tach_level;
	logic        alert_level;
	logic        tach_output_pin;
	logic        tach_output_oe;
	logic        dev_to_host_line;
	logic        dev_to_host_oe;
	logic        tach_drive_req;
	logic        tach_signal;
	logic        hall_cal_fail;
	logic [7:0]  link_status_ctrl;
	logic [15:0] user_identifier;
	logic [15:0] start_stop_thresholds;
	logic [15:0] clamp_change_points;
	logic [15:0] startup_speed_hys;
	logic [15:0] slope_primary_ctrl;
	logic [15:0] slope_secondary_ctrl;
	logic [15:0] loop_gains;
	logic [15:0] motor_hall_config;
	logic [15:0] drive_protect_config;
	logic [15:0] regs [0:8];
	logic [15:0] rv;
	logic [7:0]  sv;
	int          err_count;
	int          cmp_count;
	int          cyc;
	// pull-ups on the tach and alert pins
	assign tach_level  = tach_output_oe ? tach_output_pin : (host_oe ? host_dat : 1'b1);
	assign alert_level = dev_to_host_oe ? dev_to_host_line : 1'b1;
	assign regs = '{user_identifier, start_stop_thresholds, clamp_change_points, startup_speed_hys,
		slope_primary_ctrl, slope_secondary_ctrl, loop_gains, motor_hall_config, drive_protect_config};
	mscr_top #(.NONVOL_COMMIT_CMD_CYCLES(2000)) dut (
		.sys_clk(sys_clk), .rstn(rstn), .speed_input_pin(sck), .host_to_dev_line(tach_level),
		.tach_output_pin(tach_output_pin), .tach_output_oe(tach_output_oe),
		.dev_to_host_line(dev_to_host_line), .dev_to_host_oe(dev_to_host_oe),
		.tach_drive_req(tach_drive_req), .tach_signal(tach_signal), .hall_cal_fail(hall_cal_fail),
		.link_status_ctrl(link_status_ctrl), .user_identifier(user_identifier),
		.start_stop_thresholds(start_stop_thresholds), .clamp_change_points(clamp_change_points),
		.startup_speed_hys(startup_speed_hys), .slope_primary_ctrl(slope_primary_ctrl),
		.slope_secondary_ctrl(slope_secondary_ctrl), .loop_gains(loop_gains),
		.motor_hall_config(motor_hall_config), .drive_protect_config(drive_protect_config));
	mscr_host_model host (
		.sck(sck), .host_oe(host_oe), .host_dat(host_dat), .tach_level(tach_level), .alert_level(alert_level));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	function automatic logic [15:0] wval(input int i);
		return 16'ha5a5 ^ {4{i[3:0]}};
	endfunction
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tend(input string name);
		$display("test %s done", name);
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while (link_status_ctrl[0] !== 1'b0 && n < 3000) begin
			@(negedge sys_clk);
			n++;
		end
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			err_count++;
			print_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rstn = 1'b0;
		tach_drive_req = 1'b0;
		tach_signal = 1'b0;
		hall_cal_fail = 1'b0;
		err_count = 0;
		cmp_count = 0;
		repeat (6) @(negedge sys_clk);
		rstn = 1'b1;
		repeat (4) @(negedge sys_clk);
		check("reset status", 16'h0000, {8'h00, link_status_ctrl});
		for (int i = 0; i < 9; i++) check("reset reg", 16'h0000, regs[i]);
		tend("reset");
		host.st_wr(8'h08);
		host.reg_wr(8'h01, 16'h1234);
		host.cmd(mscr_pkg::NONVOL_COMMIT_CMD);
		check("locked write", 16'h0000, start_stop_thresholds);
		host.st_rd(sv);
		check("locked status", 16'h0008, {8'h00, sv});
		tend("locked");
		host.st_wr(8'h02);
		host.st_rd(sv);
		check("unlock status", 16'h0002, {8'h00, sv});
		for (int i = 0; i < 9; i++) host.reg_wr(i[7:0], wval(i));
		for (int i = 0; i < 9; i++) begin
			check("reg port", wval(i), regs[i]);
			host.reg_rd(i[7:0], rv);
			check("reg read", wval(i), rv);
		end
		host.reg_wr(8'h09, 16'hffff);
		host.reg_rd(8'h09, rv);
		check("unmapped read", 16'h0000, rv);
		tend("registers");
		@(negedge sys_clk);
		hall_cal_fail = 1'b1;
		repeat (2) @(negedge sys_clk);
		check("cal port", 16'h0012, {8'h00, link_status_ctrl});
		host.st_rd(sv);
		check("cal read", 16'h0012, {8'h00, sv});
		@(negedge sys_clk);
		hall_cal_fail = 1'b0;
		tend("hall");
		host.st_wr(8'h0a);
		host.cmd(mscr_pkg::NONVOL_COMMIT_CMD);
		check("commit busy", 16'h0001, {15'h0000, link_status_ctrl[0]});
		wait_idle();
		check("commit done", 16'h0000, {15'h0000, link_status_ctrl[0]});
		host.st_wr(8'h02);
		host.reg_wr(8'h01, 16'h0f0f);
		host.cmd(mscr_pkg::NONVOL_RESTORE_CMD);
		wait_idle();
		for (int i = 0; i < 9; i++) check("restore", wval(i), regs[i]);
		tend("storage");
		host.st_wr(8'h0a);
		host.reg_wr(8'h01, 16'h0f0f);
		host.cmd(mscr_pkg::NONVOL_RESTORE_CMD);
		check("restore refused", 16'h0f0f, start_stop_thresholds);
		host.cmd(mscr_pkg::NONVOL_COMMIT_CMD);
		host.cmd(mscr_pkg::NONVOL_CANCEL_CMD);
		check("cancel busy", 16'h0000, {15'h0000, link_status_ctrl[0]});
		host.st_wr(8'h02);
		host.cmd(mscr_pkg::NONVOL_RESTORE_CMD);
		wait_idle();
		check("after cancel", wval(1), start_stop_thresholds);
		tend("cancel");
		host.st_wr(8'h06);
		host.reg_rd(8'h03, rv);
		check("two wire read", wval(3), rv);
		host.st_rd(sv);
		check("two wire status", 16'h0006, {8'h00, sv});
		host.st_wr(8'h02);
		host.reg_rd(8'h04, rv);
		check("three wire read", wval(4), rv);
		tend("wire mode");
		@(negedge sys_clk);
		tach_drive_req = 1'b1;
		tach_signal = 1'b1;
		repeat (3) @(negedge sys_clk);
		check("tach drive", 16'h0003, {14'h0000, tach_output_oe, tach_output_pin});
		tach_signal = 1'b0;
		repeat (3) @(negedge sys_clk);
		check("tach low", 16'h0002, {14'h0000, tach_output_oe, tach_output_pin});
		host.reg_wr(8'h02, 16'hdead);
		tach_drive_req = 1'b0;
		repeat (3) @(negedge sys_clk);
		check("tach blocks", wval(2), clamp_change_points);
		check("tach release", 16'h0000, {15'h0000, tach_output_oe});
		tend("tach");
		print_verdict();
	end
endmodule
